// ===== logic/panel_pkg.sv
/*
 Constants, glyph codes and helpers for the alarm and setting panel.
 Assumes a 50 MHz system clock and one-cycle pulses from the store.
*/
package panel_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ     = 50_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int ALT_MS     = 2000;
    localparam int LONG_MS    = 2000;
    localparam int DEB_MS     = 10;
    localparam int BLINK_MS   = 250;
    localparam int ALT_CYC_D   = ALT_MS * CYC_PER_MS;
    localparam int LONG_CYC_D  = LONG_MS * CYC_PER_MS;
    localparam int DEB_CYC_D   = DEB_MS * CYC_PER_MS;
    localparam int BLINK_CYC_D = BLINK_MS * CYC_PER_MS;
    // ==========================================================
    // Sizes and codes
    localparam int HIST_DEPTH = 16;
    localparam int PT_TABLES  = 8;
    localparam int PT_ITEMS   = 6;
    localparam int PAR_COUNT  = 32;
    localparam logic [6:0] COUNT_MAX  = 7'h63;
    localparam logic [6:0] TEN        = 7'h0A;
    localparam logic [3:0] WIPE_DIGIT = 4'h1;
    localparam logic [2:0] ITEM_POS   = 3'h0;
    localparam int B_SET  = 0;
    localparam int B_MODE = 1;
    localparam int B_UP   = 2;
    localparam int B_DOWN = 3;
    localparam logic [4:0] G_DASH  = 5'h10;
    localparam logic [4:0] G_P     = 5'h11;
    localparam logic [4:0] G_N     = 5'h12;
    localparam logic [4:0] G_H     = 5'h13;
    localparam logic [4:0] G_BLANK = 5'h14;

    typedef enum logic [8:0] {
        ST_STAT  = 9'h001, ST_CUR = 9'h002, ST_HIST = 9'h004,
        ST_TOUGH = 9'h008, ST_REC = 9'h010, ST_PERR = 9'h020,
        ST_PT    = 9'h040, ST_PAR = 9'h080, ST_EDIT = 9'h100
    } screen_t;

    // ==========================================================
    // Helpers
    function automatic logic [6:0] seg7(input logic [4:0] g);
        case (g)
            5'h00: seg7 = 7'h3F;  5'h01: seg7 = 7'h06;  5'h02: seg7 = 7'h5B;
            5'h03: seg7 = 7'h4F;  5'h04: seg7 = 7'h66;  5'h05: seg7 = 7'h6D;
            5'h06: seg7 = 7'h7D;  5'h07: seg7 = 7'h07;  5'h08: seg7 = 7'h7F;
            5'h09: seg7 = 7'h6F;  5'h0A: seg7 = 7'h77;  5'h0B: seg7 = 7'h7C;
            5'h0C: seg7 = 7'h39;  5'h0D: seg7 = 7'h5E;  5'h0E: seg7 = 7'h79;
            5'h0F: seg7 = 7'h71;  G_DASH: seg7 = 7'h40; G_P: seg7 = 7'h73;
            G_N: seg7 = 7'h54;    G_H: seg7 = 7'h76;    default: seg7 = 7'h00;
        endcase
    endfunction

    // Item letters P d A b n H
    function automatic logic [4:0] item_glyph(input logic [2:0] it);
        case (it)
            3'h0: item_glyph = G_P;    3'h1: item_glyph = 5'h0D;
            3'h2: item_glyph = 5'h0A;  3'h3: item_glyph = 5'h0B;
            3'h4: item_glyph = G_N;    default: item_glyph = G_H;
        endcase
    endfunction

    function automatic logic [11:0] bcd3_step(input logic [11:0] v, input logic up);
        logic [11:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (c) begin
                if (up && r[i*4+:4] == 4'h9) r[i*4+:4] = 4'h0;
                else if (!up && r[i*4+:4] == 4'h0) r[i*4+:4] = 4'h9;
                else begin
                    r[i*4+:4] = up ? r[i*4+:4] + 4'h1 : r[i*4+:4] - 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction
endpackage

// ===== logic/panel_ctrl.sv
/*
 Alarm, point-table and parameter front-panel interpreter.
 Assumes raw active-low buttons and fault/enable pins from outside;
 alarm, store and event inputs come from logic on CLOCK.
*/
`timescale 1ns/1ps
// Summary of operation
// - Alarm screen blinks, alternates number/detail 2 s
// - Low two digits show alarm or parameter
// - No alarm shows dashes
// - Sixteen history entries, code shown with SET
// - Tough count 0..99, wiped by setting
// - Recorder count shown while SET held
// - Parameter error shows id while SET held
// - Point-table error: item letter then table
// - New alarm jumps to current alarm screen
// - Buttons navigate; third dot blinks during alarm
// - Clear by SET on current alarm screen, or fault-clear
// - After wipe, drive off returns to status
// - UP/DOWN step through history entries
// - Long MODE after entry restores old value
// - UP/DOWN change item, MODE next table
// - Wide values edited as two pages
// - Control scheme applies only after reset
// - Six items per point-table entry
module panel_ctrl
    import panel_pkg::*;
#(
    parameter int DEB_CYC   = panel_pkg::DEB_CYC_D,
    parameter int ALT_CYC   = panel_pkg::ALT_CYC_D,
    parameter int LONG_CYC  = panel_pkg::LONG_CYC_D,
    parameter int BLINK_CYC = panel_pkg::BLINK_CYC_D
) (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        BTN_SET_N,
    input  wire logic        BTN_MODE_N,
    input  wire logic        BTN_UP_N,
    input  wire logic        BTN_DOWN_N,
    input  wire logic        FAULT_CLEAR_INPUT,
    input  wire logic        DRIVE_ENABLE_INPUT,
    input  wire logic        ALARM_ACTIVE,
    input  wire logic        ALARM_NEW,
    input  wire logic        ALARM_CLEARABLE,
    input  wire logic [7:0]  ALARM_CODE,
    input  wire logic [3:0]  ALARM_DETAIL,
    input  wire logic        PARAM_ERR_ACTIVE,
    input  wire logic        PARAM_ERR_IS_PT,
    input  wire logic [3:0]  PARAM_ERR_GROUP,
    input  wire logic [7:0]  PARAM_ERR_NUM,
    input  wire logic [3:0]  PT_ERR_TABLE,
    input  wire logic [2:0]  PT_ERR_ITEM,
    input  wire logic        TOUGH_EVENT,
    input  wire logic        RECORDER_EVENT,
    input  wire logic        WIPE_WRITE,
    input  wire logic [11:0] WIPE_VALUE,
    input  wire logic [3:0]  CONTROL_SCHEME_STORED,
    input  wire logic        PARAM_WIDE,
    input  wire logic [23:0] EDIT_RDATA,
    output logic [7:0]       DIGIT0,
    output logic [7:0]       DIGIT1,
    output logic [7:0]       DIGIT2,
    output logic             ALARM_CLEAR,
    output logic [7:0]       EDIT_ADDR,
    output logic             EDIT_WRITE,
    output logic [23:0]      EDIT_WDATA,
    output logic [3:0]       CONTROL_SCHEME_ACTIVE
);
    import panel_pkg::*;
    localparam int DW = $clog2(DEB_CYC + 1);
    localparam int AW = $clog2(ALT_CYC + 1);
    localparam int LW = $clog2(LONG_CYC + 1);
    localparam int KW = $clog2(BLINK_CYC + 1);

    // ==========================================================
    // Button and pin conditioning
    logic [3:0]    raw, s1_r, s2_r, held_r, held_d_r, press, rel;
    logic [DW-1:0] deb_r [4];
    logic [1:0]    fc_r, en_r;
    logic          fc_d_r, fault_rise, drive_en;
    assign raw = ~{BTN_DOWN_N, BTN_UP_N, BTN_MODE_N, BTN_SET_N};

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            s1_r <= 4'h0; s2_r <= 4'h0; fc_r <= 2'h0; en_r <= 2'h0; fc_d_r <= 1'b0;
        end else begin
            s1_r   <= raw;
            s2_r   <= s1_r;
            fc_r   <= {fc_r[0], FAULT_CLEAR_INPUT};
            en_r   <= {en_r[0], DRIVE_ENABLE_INPUT};
            fc_d_r <= fc_r[1];
        end
    end
    assign fault_rise = fc_r[1] & ~fc_d_r;
    assign drive_en   = en_r[1];

    for (genvar gi = 0; gi < 4; gi++) begin : g_deb
        always_ff @(posedge CLOCK) begin
            if (SRST) begin
                deb_r[gi] <= '0; held_r[gi] <= 1'b0; held_d_r[gi] <= 1'b0;
            end else begin
                held_d_r[gi] <= held_r[gi];
                if (s2_r[gi] == held_r[gi]) deb_r[gi] <= '0;
                else if (deb_r[gi] == DW'(DEB_CYC - 1)) begin
                    held_r[gi] <= s2_r[gi];
                    deb_r[gi]  <= '0;
                end else deb_r[gi] <= deb_r[gi] + 1'b1;
            end
        end
    end
    assign press = held_r & ~held_d_r;
    assign rel   = ~held_r & held_d_r;

    // Long MODE timing from the debounced press edge
    logic [LW-1:0] long_cnt_r;
    logic          long_hit, long_done_r, mode_short;
    assign long_hit   = held_r[B_MODE] && long_cnt_r == LW'(LONG_CYC - 1);
    assign mode_short = rel[B_MODE] & ~long_done_r;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            long_cnt_r <= '0; long_done_r <= 1'b0;
        end else if (press[B_MODE]) begin
            long_cnt_r <= '0; long_done_r <= 1'b0;
        end else if (held_r[B_MODE] && !long_done_r) begin
            long_cnt_r <= long_cnt_r + 1'b1;
            if (long_hit) long_done_r <= 1'b1;
        end
    end

    // ==========================================================
    // Alarm history and counters
    logic [12:0] hist_r [HIST_DEPTH];
    logic [6:0]  tough_r, rec_r;
    logic        wipe;
    assign wipe = WIPE_WRITE && WIPE_VALUE[3:0] == WIPE_DIGIT;

    for (genvar hi = 0; hi < HIST_DEPTH; hi++) begin : g_hist
        always_ff @(posedge CLOCK) begin
            if (SRST) hist_r[hi] <= '0;
            else if (ALARM_NEW)
                hist_r[hi] <= (hi == 0) ? {1'b1, ALARM_DETAIL, ALARM_CODE}
                                        : hist_r[(hi == 0) ? 0 : hi - 1];
            else if (wipe) hist_r[hi] <= '0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            tough_r <= '0; rec_r <= '0;
        end else begin
            if (TOUGH_EVENT && tough_r != COUNT_MAX) tough_r <= tough_r + 7'h01;
            else if (wipe) tough_r <= '0;
            if (RECORDER_EVENT && rec_r != COUNT_MAX) rec_r <= rec_r + 7'h01;
        end
    end

    // Alternation and blink timers
    logic [AW-1:0] alt_cnt_r;
    logic [KW-1:0] blk_cnt_r;
    logic          alt_ph_r, blink_r;
    always_ff @(posedge CLOCK) begin
        if (SRST || ALARM_NEW || !ALARM_ACTIVE) begin
            alt_cnt_r <= '0; alt_ph_r <= 1'b0;
        end else if (alt_cnt_r == AW'(ALT_CYC - 1)) begin
            alt_cnt_r <= '0; alt_ph_r <= ~alt_ph_r;
        end else alt_cnt_r <= alt_cnt_r + 1'b1;
    end
    always_ff @(posedge CLOCK) begin
        if (SRST || !ALARM_ACTIVE) begin
            blk_cnt_r <= '0; blink_r <= 1'b1;
        end else if (blk_cnt_r == KW'(BLINK_CYC - 1)) begin
            blk_cnt_r <= '0; blink_r <= ~blink_r;
        end else blk_cnt_r <= blk_cnt_r + 1'b1;
    end

    // Alarm clear request
    screen_t     scr_r;
    always_ff @(posedge CLOCK) begin
        if (SRST) ALARM_CLEAR <= 1'b0;
        else ALARM_CLEAR <= ALARM_ACTIVE && ALARM_CLEARABLE &&
                            ((press[B_SET] && scr_r == ST_CUR) || fault_rise);
    end

    // Control scheme latched once after reset
    logic boot_r;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            boot_r <= 1'b1; CONTROL_SCHEME_ACTIVE <= 4'h0;
        end else if (boot_r) begin
            boot_r <= 1'b0; CONTROL_SCHEME_ACTIVE <= CONTROL_SCHEME_STORED;
        end
    end

    // ==========================================================
    // Screen navigation
    logic [3:0]  hidx_r, pt_r;
    logic [2:0]  item_r;
    logic [6:0]  par_r;
    logic        in_pt_r;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            scr_r <= ST_STAT; hidx_r <= '0; pt_r <= '0; item_r <= '0;
            par_r <= '0; in_pt_r <= 1'b0;
        end else if (ALARM_NEW) scr_r <= ST_CUR;
        else if (wipe && !drive_en) scr_r <= ST_STAT;
        else begin
            case (scr_r)
                ST_STAT: if (mode_short) scr_r <= ST_CUR;
                ST_CUR: begin
                    if (press[B_DOWN]) begin
                        scr_r <= ST_HIST; hidx_r <= '0;
                    end else if (press[B_UP]) scr_r <= ST_PERR;
                    else if (mode_short) scr_r <= ST_PT;
                end
                ST_HIST: begin
                    if (press[B_DOWN]) begin
                        if (hidx_r == 4'(HIST_DEPTH - 1)) scr_r <= ST_TOUGH;
                        else hidx_r <= hidx_r + 4'h1;
                    end else if (press[B_UP]) begin
                        if (hidx_r == 4'h0) scr_r <= ST_CUR;
                        else hidx_r <= hidx_r - 4'h1;
                    end else if (mode_short) scr_r <= ST_PT;
                end
                ST_TOUGH: begin
                    if (press[B_DOWN]) scr_r <= ST_REC;
                    else if (press[B_UP]) begin
                        scr_r <= ST_HIST; hidx_r <= 4'(HIST_DEPTH - 1);
                    end else if (mode_short) scr_r <= ST_PT;
                end
                ST_REC: begin
                    if (press[B_DOWN]) scr_r <= ST_PERR;
                    else if (press[B_UP]) scr_r <= ST_TOUGH;
                    else if (mode_short) scr_r <= ST_PT;
                end
                ST_PERR: begin
                    if (press[B_DOWN]) scr_r <= ST_CUR;
                    else if (press[B_UP]) scr_r <= ST_REC;
                    else if (mode_short) scr_r <= ST_PT;
                end
                ST_PT: begin
                    if (press[B_DOWN])
                        item_r <= (item_r == 3'(PT_ITEMS - 1)) ? 3'h0 : item_r + 3'h1;
                    else if (press[B_UP])
                        item_r <= (item_r == 3'h0) ? 3'(PT_ITEMS - 1) : item_r - 3'h1;
                    else if (mode_short) begin
                        if (pt_r == 4'(PT_TABLES - 1)) begin
                            scr_r <= ST_PAR; pt_r <= '0;
                        end else pt_r <= pt_r + 4'h1;
                    end else if (press[B_SET]) begin
                        scr_r <= ST_EDIT; in_pt_r <= 1'b1;
                    end
                end
                ST_PAR: begin
                    if (press[B_DOWN]) par_r <= 7'((par_r + 7'h01) % PAR_COUNT);
                    else if (press[B_UP])
                        par_r <= (par_r == 7'h00) ? 7'(PAR_COUNT - 1) : par_r - 7'h01;
                    else if (mode_short) scr_r <= ST_STAT;
                    else if (press[B_SET]) begin
                        scr_r <= ST_EDIT; in_pt_r <= 1'b0;
                    end
                end
                ST_EDIT: if (press[B_SET]) scr_r <= in_pt_r ? ST_PT : ST_PAR;
                default: scr_r <= ST_STAT;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) EDIT_ADDR <= 8'h00;
        else EDIT_ADDR <= (scr_r == ST_PT || (scr_r == ST_EDIT && in_pt_r))
                          ? {1'b1, pt_r, item_r} : {1'b0, par_r};
    end

    // ==========================================================
    // Value editing, entry and cancel
    logic [23:0] val_r, prev_r;
    logic        page_r, just_r, wide, browse;
    assign wide   = in_pt_r ? item_r == ITEM_POS : PARAM_WIDE;
    assign browse = scr_r == ST_PT || scr_r == ST_PAR;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            val_r <= '0; prev_r <= '0; page_r <= 1'b0; just_r <= 1'b0;
            EDIT_WRITE <= 1'b0; EDIT_WDATA <= '0;
        end else begin
            EDIT_WRITE <= 1'b0;
            if (just_r && long_hit && browse) begin
                EDIT_WRITE <= 1'b1; EDIT_WDATA <= prev_r; just_r <= 1'b0;
            end else if (|press[B_DOWN:B_UP] || press[B_SET] || mode_short)
                just_r <= 1'b0;
            if (browse && press[B_SET]) begin
                val_r <= EDIT_RDATA; page_r <= 1'b0;
            end
            if (scr_r == ST_EDIT) begin
                if (press[B_UP] || press[B_DOWN])
                    val_r[page_r*12+:12] <= bcd3_step(val_r[page_r*12+:12], press[B_UP]);
                else if (mode_short && wide) page_r <= ~page_r;
                else if (press[B_SET]) begin
                    EDIT_WRITE <= 1'b1; EDIT_WDATA <= val_r;
                    prev_r <= EDIT_RDATA; just_r <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Display composition
    logic [4:0]  g2, g1, g0;
    logic [12:0] he;
    assign he = hist_r[hidx_r];
    always_comb begin
        g2 = G_BLANK; g1 = G_BLANK; g0 = G_BLANK;
        case (scr_r)
            ST_CUR: begin
                if (!ALARM_ACTIVE) begin
                    g2 = G_DASH; g1 = G_DASH; g0 = G_DASH;
                end else if (blink_r && !alt_ph_r) begin
                    g1 = {1'b0, ALARM_CODE[7:4]}; g0 = {1'b0, ALARM_CODE[3:0]};
                end else if (blink_r) g0 = {1'b0, ALARM_DETAIL};
            end
            ST_HIST: begin
                if (held_r[B_SET] && he[12]) begin
                    g2 = {1'b0, he[11:8]}; g1 = {1'b0, he[7:4]}; g0 = {1'b0, he[3:0]};
                end else if (held_r[B_SET]) begin
                    g1 = G_DASH; g0 = G_DASH;
                end else begin
                    g2 = G_H; g0 = {1'b0, hidx_r};
                end
            end
            ST_TOUGH: begin
                g1 = 5'(tough_r / TEN); g0 = 5'(tough_r % TEN);
            end
            ST_REC: begin
                if (held_r[B_SET]) begin
                    g1 = 5'(rec_r / TEN); g0 = 5'(rec_r % TEN);
                end else g2 = G_DASH;
            end
            ST_PERR: begin
                if (!PARAM_ERR_ACTIVE) begin
                    g2 = G_DASH; g1 = G_DASH; g0 = G_DASH;
                end else if (!held_r[B_SET]) g2 = G_P;
                else if (PARAM_ERR_IS_PT) begin
                    g2 = item_glyph(PT_ERR_ITEM); g0 = {1'b0, PT_ERR_TABLE};
                end else begin
                    g2 = {1'b0, PARAM_ERR_GROUP};
                    g1 = {1'b0, PARAM_ERR_NUM[7:4]}; g0 = {1'b0, PARAM_ERR_NUM[3:0]};
                end
            end
            ST_PT: begin
                g2 = item_glyph(item_r); g1 = G_DASH; g0 = {1'b0, pt_r};
            end
            ST_PAR: begin
                g2 = G_P; g1 = {2'b00, par_r[6:4]}; g0 = {1'b0, par_r[3:0]};
            end
            ST_EDIT: begin
                g2 = {1'b0, val_r[page_r*12+8+:4]};
                g1 = {1'b0, val_r[page_r*12+4+:4]};
                g0 = {1'b0, val_r[page_r*12+:4]};
            end
            default: g0 = G_BLANK;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            DIGIT0 <= 8'h00; DIGIT1 <= 8'h00; DIGIT2 <= 8'h00;
        end else begin
            DIGIT0 <= {1'b0, seg7(g0)};
            DIGIT1 <= {1'b0, seg7(g1)};
            DIGIT2 <= {ALARM_ACTIVE & blink_r, seg7(g2)};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    a_alarm_jump:  assert property (ALARM_NEW |=> scr_r == ST_CUR)
        else $error("alarm did not show current screen");
    a_clear_button: assert property (press[B_SET] && scr_r == ST_CUR && ALARM_ACTIVE
        && ALARM_CLEARABLE |=> ALARM_CLEAR) else $error("SET did not clear alarm");
    a_tough_bound: assert property (tough_r <= COUNT_MAX)
        else $error("tough count above limit");
    a_wipe_tough:  assert property (wipe && !TOUGH_EVENT |=> tough_r == 7'h00)
        else $error("wipe left tough count");
    a_dot_idle:    assert property (!ALARM_ACTIVE |=> !DIGIT2[7])
        else $error("dot lit with no alarm");
    a_status_back: assert property (wipe && !drive_en && !ALARM_NEW
        |=> scr_r == ST_STAT) else $error("no return to status");
    a_cancel_restore: assert property (just_r && long_hit && browse
        |=> EDIT_WRITE && EDIT_WDATA == $past(prev_r)) else $error("cancel failed");
    a_hist_step:   assert property (scr_r == ST_HIST && press[B_DOWN] && hidx_r != 4'hF
        && !ALARM_NEW && !wipe |=> hidx_r == $past(hidx_r) + 4'h1) else $error("bad step");
    a_alt_phase:   assert property (ALARM_ACTIVE && !ALARM_NEW && alt_cnt_r == AW'(ALT_CYC - 1)
        |=> alt_ph_r != $past(alt_ph_r)) else $error("phase did not switch");
endmodule

// ===== tb/panel_operator.sv
/*
 Operator model: presses the four panel buttons.
 Assumes active-low raw buttons sampled on CLOCK.
*/
`timescale 1ns/1ps
module panel_operator (
    input  wire logic       CLOCK,
    output logic [3:0]      BTN_N
);
    initial BTN_N = 4'hF;
    // Clean press, held for hold cycles, then idle gap
    task automatic press(input int b, input int hold);
        @(posedge CLOCK);
        BTN_N[b] <= 1'b0;
        repeat (hold) @(posedge CLOCK);
        BTN_N[b] <= 1'b1;
        repeat (12) @(posedge CLOCK);
    endtask
    // Short glitch below the debounce time
    task automatic bounce(input int b);
        @(posedge CLOCK);
        BTN_N[b] <= 1'b0;
        repeat (2) @(posedge CLOCK);
        BTN_N[b] <= 1'b1;
        repeat (12) @(posedge CLOCK);
    endtask
endmodule

// ===== tb/alarm_and_setting_panel_ctrl_tb.sv
/*
 Self-checking bench for panel_ctrl with short timing parameters.
 Assumes the operator model drives the buttons.
*/
`timescale 1ns/1ps
module alarm_and_setting_panel_ctrl_tb;
    import panel_pkg::*;
    logic CLOCK = 0, SRST = 1, FCLR = 0, DEN = 0, AACT = 0, ANEW = 0, ACLR_OK = 0;
    logic TEV = 0, REV = 0, WW = 0, PWIDE = 0;
    logic [3:0] SCHEME = 4'h3;
    logic [7:0] CODE = 8'h33, PNUM = 8'h12;
    logic [3:0] DET = 4'h1, PGRP = 4'hA, PTT = 4'h1;
    logic [2:0] PTI = 3'h2;
    logic [11:0] WVAL = 12'h001;
    logic [23:0] RDATA = 24'h0000_0123;
    logic [3:0] BTN_N;
    logic [7:0] D0, D1, D2, ADDR, addr_seen;
    logic ACLR, EWR;
    logic [23:0] WDATA, wdata_seen;
    logic [3:0] ACT;
    int n_errors = 0, checks_done = 0, n_clr = 0, n_wr = 0;
    logic dot_seen = 0, code_seen = 0, det_seen = 0;
    initial forever #10 CLOCK = ~CLOCK;
    panel_operator op (.CLOCK(CLOCK), .BTN_N(BTN_N));
    panel_ctrl #(.DEB_CYC(4), .ALT_CYC(20), .LONG_CYC(30), .BLINK_CYC(5)) dut (
        .CLOCK(CLOCK), .SRST(SRST), .BTN_SET_N(BTN_N[B_SET]), .BTN_MODE_N(BTN_N[B_MODE]),
        .BTN_UP_N(BTN_N[B_UP]), .BTN_DOWN_N(BTN_N[B_DOWN]), .FAULT_CLEAR_INPUT(FCLR),
        .DRIVE_ENABLE_INPUT(DEN), .ALARM_ACTIVE(AACT), .ALARM_NEW(ANEW),
        .ALARM_CLEARABLE(ACLR_OK), .ALARM_CODE(CODE), .ALARM_DETAIL(DET),
        .PARAM_ERR_ACTIVE(AACT), .PARAM_ERR_IS_PT(PWIDE), .PARAM_ERR_GROUP(PGRP),
        .PARAM_ERR_NUM(PNUM), .PT_ERR_TABLE(PTT), .PT_ERR_ITEM(PTI), .TOUGH_EVENT(TEV),
        .RECORDER_EVENT(REV), .WIPE_WRITE(WW), .WIPE_VALUE(WVAL),
        .CONTROL_SCHEME_STORED(SCHEME), .PARAM_WIDE(PWIDE), .EDIT_RDATA(RDATA),
        .DIGIT0(D0), .DIGIT1(D1), .DIGIT2(D2), .ALARM_CLEAR(ACLR), .EDIT_ADDR(ADDR),
        .EDIT_WRITE(EWR), .EDIT_WDATA(WDATA), .CONTROL_SCHEME_ACTIVE(ACT));
    // ==========================================================
    // Output monitor
    always @(posedge CLOCK) begin
        if (ACLR === 1'b1) n_clr <= n_clr + 1;
        if (EWR === 1'b1) begin
            n_wr <= n_wr + 1;
            wdata_seen <= WDATA;
            addr_seen <= ADDR;
        end
        if (D2[7] === 1'b1) dot_seen <= 1'b1;
        if (D1 === 8'h4F && D0 === 8'h4F) code_seen <= 1'b1;
        if (D1 === 8'h00 && D0 === 8'h06) det_seen <= 1'b1;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic wipe_pulse();
        WW <= 1'b1;
        cyc(1);
        WW <= 1'b0;
        cyc(3);
    endtask
    // Compares all three digits midway through a held SET press
    task automatic held_chk(input string what, input logic [23:0] exp);
        fork
            op.press(B_SET, 20);
            begin
                cyc(15);
                chk(what, exp, 24'({D2[6:0], D1, D0}));
            end
        join
    endtask
    task automatic do_reset();
        @(posedge CLOCK) SRST <= 1'b1;
        cyc(6);
        SRST <= 1'b0;
        cyc(3);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #1ms;
        n_errors++;
        final_report();
    end
    // ==========================================================
    // Tests
    initial begin
        do_reset();
        chk("scheme", 24'h3, 24'(ACT));
        SCHEME <= 4'h5;
        cyc(3);
        chk("scheme kept", 24'h3, 24'(ACT));
        op.press(B_MODE, 8);
        chk("no alarm", 24'h40, 24'(D0));
        $display("test reset done");
        AACT <= 1'b1;
        ACLR_OK <= 1'b1;
        ANEW <= 1'b1;
        TEV <= 1'b1;
        REV <= 1'b1;
        cyc(1);
        ANEW <= 1'b0;
        TEV <= 1'b0;
        REV <= 1'b0;
        cyc(30);
        chk("dot", 24'h1, 24'(dot_seen));
        chk("alternation", 24'h3, 24'({code_seen, det_seen}));
        op.bounce(B_SET);
        chk("bounce clear", 24'h0, 24'(n_clr));
        op.press(B_SET, 8);
        chk("set clear", 24'h1, 24'(n_clr));
        ACLR_OK <= 1'b0;
        FCLR <= 1'b1;
        cyc(6);
        FCLR <= 1'b0;
        cyc(6);
        chk("no clear", 24'h1, 24'(n_clr));
        ACLR_OK <= 1'b1;
        FCLR <= 1'b1;
        cyc(6);
        FCLR <= 1'b0;
        cyc(6);
        chk("fault clear", 24'h2, 24'(n_clr));
        DEN <= 1'b1;
        op.press(B_DOWN, 8);
        held_chk("history entry", 24'h064F_4F);
        op.press(B_DOWN, 8);
        chk("history index", 24'h0076_06, 24'({D2[6:0], D0}));
        op.press(B_UP, 8);
        op.press(B_UP, 8);
        op.press(B_UP, 8);
        chk("param error", 24'h73, 24'(D2[6:0]));
        held_chk("param id", 24'h7706_5B);
        PWIDE <= 1'b1;
        held_chk("table error", 24'h7700_06);
        PWIDE <= 1'b0;
        op.press(B_UP, 8);
        held_chk("recorder count", 24'h003F_06);
        op.press(B_UP, 8);
        chk("tough", 24'h003F_06, 24'({D1, D0}));
        AACT <= 1'b0;
        WVAL <= 12'h000;
        wipe_pulse();
        chk("tough kept", 24'h003F_06, 24'({D1, D0}));
        WVAL <= 12'h001;
        wipe_pulse();
        chk("tough wiped", 24'h003F_3F, 24'({D1, D0}));
        DEN <= 1'b0;
        cyc(3);
        wipe_pulse();
        chk("status", 24'h0, 24'({D2, D1, D0}));
        $display("test alarm done");
        do_reset();
        chk("scheme new", 24'h5, 24'(ACT));
        op.press(B_MODE, 8);
        op.press(B_MODE, 8);
        op.press(B_SET, 8);
        op.press(B_UP, 8);
        op.press(B_MODE, 8);
        op.press(B_UP, 8);
        op.press(B_SET, 8);
        chk("writes", 24'h1, 24'(n_wr));
        chk("paged value", 24'h0011_24, wdata_seen);
        chk("item", 24'h8, 24'({addr_seen[7], addr_seen[2:0]}));
        op.press(B_MODE, 40);
        chk("undo writes", 24'h2, 24'(n_wr));
        chk("undo value", 24'h0001_23, wdata_seen);
        $display("test edit done");
        final_report();
    end
endmodule
